// [src/adcce_pkg.sv]
// Package: constants and types of the converter serial command engine
package adcce_pkg;
	localparam int          CLK_MHZ            = 100;
	localparam int          RESUME_COMM_MS     = 10;
	localparam int          RESUME_COMM_CYC    = RESUME_COMM_MS * 1000 * CLK_MHZ;
	localparam int          RESULT_W           = 24;
	localparam int          NUM_REGS           = 16;
	localparam int          CAL_SAMPLES        = 16;
	localparam int          CAL_MOD_CLKS       = 32;
	localparam int          CAL_OSC_CLKS       = 50;
	localparam logic [23:0] OFFSET_COEF_RST    = 24'h000000;
	localparam logic [23:0] GAIN_COEF_RST      = 24'h400000;
	localparam logic [3:0]  OFC_ADDR0          = 4'h4;
	localparam logic [3:0]  GAIN_ADDR0         = 4'h7;
	localparam logic [6:0]  OP_SINGLE_READ     = 7'h09;
	localparam logic [6:0]  OP_CONT_READ       = 7'h0a;
	localparam logic [6:0]  OP_STOP_CONT       = 7'h0b;
	localparam logic [6:0]  OP_POWER_ON_INIT   = 7'h07;
	localparam logic [3:0]  OP_REG_READ        = 4'h2;
	localparam logic [3:0]  OP_REG_WRITE       = 4'h4;
	localparam logic [7:0]  OP_SYS_OFFSET_CAL  = 8'h60;
	localparam logic [7:0]  OP_SYS_GAIN_CAL    = 8'h61;
	localparam logic [7:0]  OP_SELF_OFFSET_CAL = 8'h62;
	localparam logic [31:0] AHB_OFS_CONTROL    = 32'h0000_0000;
	localparam logic [31:0] AHB_OFS_STATUS     = 32'h0000_0004;
	localparam logic [31:0] AHB_OFS_RESULT     = 32'h0000_0008;
	localparam logic [31:0] AHB_OFS_OFFSET     = 32'h0000_000c;
	localparam logic [31:0] AHB_OFS_GAIN       = 32'h0000_0010;
	typedef enum logic [1:0] {ADCCE_CAL_SYS_OFS, ADCCE_CAL_SYS_GAIN, ADCCE_CAL_SELF_OFS} adcce_cal_t;
endpackage

// [src/adcce_cal_if.sv]
// Interface: calibration request and completion between engine and sequencer
`timescale 1ns/10ps
`default_nettype none
interface adcce_cal_if;
	import adcce_pkg::*;
	logic        start;
	adcce_cal_t  kind;
	logic        busy;
	logic        done;
	adcce_cal_t  done_kind;
	logic [23:0] coef;
	logic        short_inputs;
	modport engine (output start, output kind, input busy, input done, input done_kind, input coef,
		input short_inputs);
	modport seq    (input start, input kind, output busy, output done, output done_kind, output coef,
		output short_inputs);
endinterface
`default_nettype wire

// [src/adcce_cal_seq.sv]
// Calibration sequencer: averages conversions and times the operation
`timescale 1ns/10ps
`default_nettype none
module adcce_cal_seq #(
	parameter int MOD_DIV = 4,
	parameter int OSC_DIV = 24
) (
	// Clock and reset
	input  wire logic           clk_i,
	input  wire logic           rst_n_i,
	input  wire logic           ce_i,
	// Conversion stream
	input  wire logic           conv_valid_i,
	input  wire logic [23:0]    conv_data_i,
	// Engine side
	adcce_cal_if.seq            cal
);
	import adcce_pkg::*;

	typedef enum logic [1:0] {ADCCE_CS_IDLE, ADCCE_CS_MOD, ADCCE_CS_CONV, ADCCE_CS_OSC} adcce_cs_t;
	adcce_cs_t   state_q;
	logic [31:0] cnt_q;
	logic [4:0]  nsamp_q;
	logic [27:0] acc_q;
	adcce_cal_t  kind_q;

	assign cal.busy         = (state_q != ADCCE_CS_IDLE);
	assign cal.done_kind    = kind_q;
	assign cal.short_inputs = cal.busy && (kind_q == ADCCE_CAL_SELF_OFS);

	// Duration: 32 mod clocks + 16 conversions + 50 osc clocks
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q  <= ADCCE_CS_IDLE;
			cnt_q    <= '0;
			nsamp_q  <= '0;
			acc_q    <= '0;
			kind_q   <= ADCCE_CAL_SYS_OFS;
			cal.done <= 1'b0;
			cal.coef <= '0;
		end else if (ce_i) begin
			cal.done <= 1'b0;
			case (state_q)
				ADCCE_CS_IDLE: begin
					if (cal.start) begin
						state_q <= ADCCE_CS_MOD;
						kind_q  <= cal.kind;
						cnt_q   <= 32'(CAL_MOD_CLKS * MOD_DIV);
						nsamp_q <= '0;
						acc_q   <= '0;
					end
				end
				ADCCE_CS_MOD: begin
					if (cnt_q <= 32'd1) begin
						state_q <= ADCCE_CS_CONV;
					end else begin
						cnt_q <= cnt_q - 32'd1;
					end
				end
				ADCCE_CS_CONV: begin
					if (conv_valid_i) begin
						acc_q   <= acc_q + 28'({{4{conv_data_i[23]}}, conv_data_i});
						nsamp_q <= nsamp_q + 5'd1;
						if (nsamp_q == 5'(CAL_SAMPLES - 1)) begin
							state_q <= ADCCE_CS_OSC;
							cnt_q   <= 32'(CAL_OSC_CLKS * OSC_DIV);
						end
					end
				end
				default: begin
					if (cnt_q <= 32'd1) begin
						state_q  <= ADCCE_CS_IDLE;
						cal.done <= 1'b1;
						cal.coef <= acc_q[27:4];
					end else begin
						cnt_q <= cnt_q - 32'd1;
					end
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// [src/adcce_top.sv]
// Serial command engine of a delta-sigma converter, with AHB-Lite register view
//
// Decided for this implementation: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
module adcce_top #(
	parameter int RESUME_CYC = adcce_pkg::RESUME_COMM_CYC,
	parameter int MOD_DIV    = 4,
	parameter int OSC_DIV    = 24
) (
	// Clock, reset, enable
	input  wire logic        core_clk_i,
	input  wire logic        resetn_i,
	input  wire logic        ce_i,
	// Serial link
	input  wire logic        sclk_i,
	input  wire logic        cs_n_i,
	input  wire logic        mosi_i,
	output logic             miso_o,
	output logic             miso_oe_o,
	output logic             result_ready_n_o,
	// Converter core
	input  wire logic        conv_valid_i,
	input  wire logic [23:0] conv_data_i,
	output logic             short_inputs_o,
	output logic             cal_busy_o,
	// AHB-Lite slave
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic        hready_i,
	input  wire logic [31:0] hwdata_i,
	output logic [31:0]      hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o
);
	import adcce_pkg::*;

	// =========================================================
	// Reset and input synchronisers
	logic [1:0] rst_sq;
	logic       rst_n;
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_sq <= 2'b00;
		end else begin
			rst_sq <= {rst_sq[0], 1'b1};
		end
	end
	assign rst_n = rst_sq[1];

	logic [2:0] s1_q, s2_q;
	logic       sclk_d1_q;
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			s1_q      <= 3'b010;
			s2_q      <= 3'b010;
			sclk_d1_q <= 1'b0;
		end else if (ce_i) begin
			s1_q      <= {sclk_i, cs_n_i, mosi_i};
			s2_q      <= s1_q;
			sclk_d1_q <= s2_q[2];
		end
	end
	logic sclk_s, cs_n_s, mosi_s, sclk_rise, sclk_fall;
	assign sclk_s    = s2_q[2];
	assign cs_n_s    = s2_q[1];
	assign mosi_s    = s2_q[0];
	assign sclk_rise = sclk_s && !sclk_d1_q;
	assign sclk_fall = !sclk_s && sclk_d1_q;

	// =========================================================
	// Register array and coefficients
	logic [7:0]  regs_q [NUM_REGS];
	logic [23:0] result_q;
	logic        cont_q, cont_pend_q, stop_pend_q;
	logic        ready_n_q;
	logic [31:0] resume_q;

	adcce_cal_if cal_bus ();
	adcce_cal_seq #(
		.MOD_DIV (MOD_DIV),
		.OSC_DIV (OSC_DIV)
	) u_cal (
		.clk_i        (core_clk_i),
		.rst_n_i      (rst_n),
		.ce_i         (ce_i),
		.conv_valid_i (conv_valid_i),
		.conv_data_i  (conv_data_i),
		.cal          (cal_bus.seq)
	);
	assign short_inputs_o = cal_bus.short_inputs;
	assign cal_busy_o     = cal_bus.busy;

	function automatic logic is_offset_kind(input adcce_cal_t k);
		return (k != ADCCE_CAL_SYS_GAIN);
	endfunction

	// =========================================================
	// Serial shifter and command decoder
	typedef enum logic [2:0] {ADCCE_CMD, ADCCE_CNT, ADCCE_WDATA, ADCCE_RDATA, ADCCE_SKIP} adcce_st_t;
	adcce_st_t   st_q;
	logic [2:0]  bit_q;
	logic [7:0]  in_q;
	logic [7:0]  out_q;
	logic [3:0]  ptr_q, left_q;
	logic [4:0]  res_left_q;
	logic        res_active_q;
	logic        is_read_q;
	logic        byte_done;
	logic [7:0]  byte_in;
	logic        reg_we;
	logic [3:0]  reg_wa;
	logic [7:0]  reg_wd;
	logic        load_result;
	logic        ready_fall;
	logic        hold_q;
	logic        miso_q;

	assign byte_in   = {in_q[6:0], mosi_s};
	assign byte_done = sclk_rise && !cs_n_s && (bit_q == 3'd7);

	always_comb begin
		reg_we = 1'b0;
		reg_wa = ptr_q;
		reg_wd = byte_in;
		if (byte_done && st_q == ADCCE_WDATA) begin
			reg_we = 1'b1;
		end
	end

	// Loading: new result into shifter when ready falls in continuous mode, except during a register readout
	assign ready_fall  = conv_valid_i && !cal_bus.busy;
	assign load_result = ready_fall && cont_q && st_q != ADCCE_RDATA;

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			st_q         <= ADCCE_CMD;
			bit_q        <= '0;
			in_q         <= '0;
			out_q        <= '0;
			ptr_q        <= '0;
			left_q       <= '0;
			res_left_q   <= '0;
			res_active_q <= 1'b0;
			is_read_q    <= 1'b0;
			cont_q       <= 1'b1;
			cont_pend_q  <= 1'b0;
			stop_pend_q  <= 1'b0;
			cal_bus.start <= 1'b0;
			cal_bus.kind  <= ADCCE_CAL_SYS_OFS;
			resume_q     <= '0;
		end else if (ce_i) begin
			cal_bus.start <= 1'b0;
			if (resume_q != 32'd0) begin
				resume_q <= resume_q - 32'd1;
			end
			// Mode changes land at the next ready fall
			if (ready_fall) begin
				if (cont_pend_q) begin
					cont_q <= 1'b1;
				end
				if (stop_pend_q) begin
					cont_q <= 1'b0;
				end
				cont_pend_q <= 1'b0;
				stop_pend_q <= 1'b0;
			end
			if (load_result) begin
				out_q        <= conv_data_i[23:16];
				res_left_q   <= 5'd2;
				res_active_q <= 1'b1;
			end
			if (cs_n_s) begin
				// Select high resets framing; result stays for next frame
				st_q  <= ADCCE_CMD;
				bit_q <= '0;
			end else if (sclk_fall && !load_result && !hold_q) begin
				out_q <= {out_q[6:0], 1'b0};
			end
			if (sclk_rise && !cs_n_s) begin
				bit_q <= bit_q + 3'd1;
				in_q  <= byte_in;
			end
			if (byte_done && !load_result) begin
				// Next output byte: register data or rest of result
				if (st_q == ADCCE_RDATA) begin
					out_q <= regs_q[ptr_q];
				end else if (res_active_q && res_left_q != 5'd0) begin
					out_q      <= (res_left_q == 5'd2) ? result_q[15:8] : result_q[7:0];
					res_left_q <= res_left_q - 5'd1;
				end else begin
					res_active_q <= 1'b0;
					out_q        <= '0;
				end
				case (st_q)
					ADCCE_CMD: begin
						// Single read may arrive during last result byte
						if (byte_in[7:1] == OP_SINGLE_READ) begin
							out_q        <= result_q[23:16];
							res_left_q   <= 5'd2;
							res_active_q <= 1'b1;
						end else if (byte_in[7:1] == OP_CONT_READ) begin
							cont_pend_q <= 1'b1;
							stop_pend_q <= 1'b0;
						end else if (byte_in[7:1] == OP_STOP_CONT) begin
							stop_pend_q <= 1'b1;
							cont_pend_q <= 1'b0;
						end else if (byte_in[7:1] == OP_POWER_ON_INIT) begin
							resume_q <= 32'(RESUME_CYC);
						end else if (byte_in[7:4] == OP_REG_READ || byte_in[7:4] == OP_REG_WRITE) begin
							ptr_q     <= byte_in[3:0];
							is_read_q <= (byte_in[7:4] == OP_REG_READ);
							st_q      <= ADCCE_CNT;
						end else if (!cal_bus.busy && (byte_in == OP_SYS_OFFSET_CAL || byte_in == OP_SYS_GAIN_CAL ||
								byte_in == OP_SELF_OFFSET_CAL)) begin
							cal_bus.start <= 1'b1;
							cal_bus.kind  <= adcce_cal_t'(byte_in[1:0]);
						end
					end
					ADCCE_CNT: begin
						left_q <= byte_in[3:0];
						if (is_read_q) begin
							st_q         <= ADCCE_RDATA;
							out_q        <= regs_q[ptr_q];
							res_active_q <= 1'b0;
						end else begin
							st_q <= ADCCE_WDATA;
						end
					end
					ADCCE_WDATA, ADCCE_RDATA: begin
						// Readout bytes are ignored as commands
						ptr_q  <= ptr_q + 4'd1;
						left_q <= left_q - 4'd1;
						if (st_q == ADCCE_RDATA) begin
							out_q <= regs_q[4'(ptr_q + 4'd1)];
						end
						if (left_q == 4'd0) begin
							st_q <= ADCCE_CMD;
							if (st_q == ADCCE_RDATA) begin
								out_q <= '0;
							end
						end
					end
					default: st_q <= ADCCE_CMD;
				endcase
			end
		end
	end

	// Latest result and ready pin (low from result until read begins)
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			result_q  <= '0;
			ready_n_q <= 1'b1;
		end else if (ce_i) begin
			if (ready_fall) begin
				result_q  <= conv_data_i;
				ready_n_q <= 1'b0;
			end else if (!cs_n_s && sclk_rise) begin
				ready_n_q <= 1'b1;
			end
		end
	end
	assign result_ready_n_o = ready_n_q;

	// =========================================================
	// Serial output stage
	// Next byte loads at the eighth rise; the pin keeps the
	// old last bit until its fall, else the host reads early
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			hold_q <= 1'b0;
			miso_q <= 1'b0;
		end else if (ce_i) begin
			if (cs_n_s || sclk_fall) begin
				hold_q <= 1'b0;
			end else if (byte_done) begin
				hold_q <= 1'b1;
			end
			if (!hold_q) begin
				miso_q <= out_q[7];
			end
		end
	end
	assign miso_o           = miso_q;
	assign miso_oe_o        = !cs_n_s;

	// =========================================================
	// AHB-Lite slave
	logic        ahb_we_q;
	logic [31:0] ahb_addr_q;
	logic [31:0] rdata;
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ahb_we_q   <= 1'b0;
			ahb_addr_q <= '0;
		end else if (ce_i) begin
			ahb_we_q   <= hsel_i && hready_i && htrans_i[1] && hwrite_i;
			if (hsel_i && hready_i && htrans_i[1]) begin
				ahb_addr_q <= haddr_i;
			end
		end
	end

	// Register storage: serial writes, AHB writes, calibration results
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				regs_q[i] <= '0;
			end
			{regs_q[OFC_ADDR0 + 4'd2], regs_q[OFC_ADDR0 + 4'd1], regs_q[OFC_ADDR0]} <= OFFSET_COEF_RST;
			{regs_q[GAIN_ADDR0 + 4'd2], regs_q[GAIN_ADDR0 + 4'd1], regs_q[GAIN_ADDR0]} <= GAIN_COEF_RST;
		end else if (ce_i) begin
			if (reg_we) begin
				regs_q[reg_wa] <= reg_wd;
			end
			if (ahb_we_q && ahb_addr_q == AHB_OFS_CONTROL) begin
				regs_q[hwdata_i[11:8]] <= hwdata_i[7:0];
			end
			if (cal_bus.done) begin
				if (is_offset_kind(cal_bus.done_kind)) begin
					{regs_q[OFC_ADDR0 + 4'd2], regs_q[OFC_ADDR0 + 4'd1], regs_q[OFC_ADDR0]} <= cal_bus.coef;
				end else begin
					{regs_q[GAIN_ADDR0 + 4'd2], regs_q[GAIN_ADDR0 + 4'd1], regs_q[GAIN_ADDR0]} <= cal_bus.coef;
				end
			end
		end
	end

	always_comb begin
		if (ahb_addr_q == AHB_OFS_STATUS) begin
			rdata = {26'h0, resume_q != 32'd0, st_q != ADCCE_CMD, cont_pend_q, stop_pend_q, cal_bus.busy, cont_q};
		end else if (ahb_addr_q == AHB_OFS_RESULT) begin
			rdata = {8'h00, result_q};
		end else if (ahb_addr_q == AHB_OFS_OFFSET) begin
			rdata = {8'h00, regs_q[OFC_ADDR0 + 4'd2], regs_q[OFC_ADDR0 + 4'd1], regs_q[OFC_ADDR0]};
		end else if (ahb_addr_q == AHB_OFS_GAIN) begin
			rdata = {8'h00, regs_q[GAIN_ADDR0 + 4'd2], regs_q[GAIN_ADDR0 + 4'd1], regs_q[GAIN_ADDR0]};
		end else begin
			rdata = 32'h0000_0000;
		end
	end
	assign hrdata_o    = rdata;
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;
endmodule
`default_nettype wire

// [tb/adcce_checker.sv]
// Checker: port-level properties of the serial command engine
`timescale 1ns/10ps
`default_nettype none
module adcce_checker
	import adcce_pkg::*;
#(
	parameter int RESUME_CYC = 100,
	parameter int MOD_DIV    = 1,
	parameter int OSC_DIV    = 1
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic resetn_i,
	// Serial link
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic miso_oe_o,
	input wire logic result_ready_n_o,
	// Converter and bus
	input wire logic conv_valid_i,
	input wire logic short_inputs_o,
	input wire logic cal_busy_o,
	input wire logic hreadyout_o,
	input wire logic hresp_o
);
	logic [7:0]  conv_cnt_q;
	logic [15:0] cyc_cnt_q;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);
	// ========
	// Calibration counters, cleared while idle
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			conv_cnt_q <= 8'h0;
		end else if (!cal_busy_o) begin
			conv_cnt_q <= 8'h0;
		end else if (conv_valid_i) begin
			conv_cnt_q <= conv_cnt_q + 8'h1;
		end
	end
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cyc_cnt_q <= 16'h0;
		end else if (!cal_busy_o) begin
			cyc_cnt_q <= 16'h0;
		end else begin
			cyc_cnt_q <= cyc_cnt_q + 16'h1;
		end
	end
	// ========
	// Properties
	property p_bus_okay;
		hreadyout_o && !hresp_o;
	endproperty
	a_bus_okay: assert property (p_bus_okay) else $error("bus answer not zero-wait okay");
	property p_ready_fall;
		conv_valid_i && !cal_busy_o && cs_n_i |-> ##[1:3] !result_ready_n_o;
	endproperty
	a_ready_fall: assert property (p_ready_fall) else $error("ready did not fall after result");
	property p_ready_cause;
		$fell(result_ready_n_o) |-> $past(conv_valid_i) || $past(conv_valid_i, 2) || $past(conv_valid_i, 3);
	endproperty
	a_ready_cause: assert property (p_ready_cause) else $error("ready fell without a result");
	property p_ready_clear;
		$rose(sclk_i) && !cs_n_i |-> ##[1:6] result_ready_n_o;
	endproperty
	a_ready_clear: assert property (p_ready_clear) else $error("ready not cleared by clocking");
	property p_oe_on;
		$fell(cs_n_i) |-> ##[1:4] miso_oe_o;
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("output not enabled on select");
	property p_oe_off;
		$rose(cs_n_i) |-> ##[1:4] !miso_oe_o;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("output still enabled after select");
	property p_cal_samples;
		$fell(cal_busy_o) |-> conv_cnt_q >= 8'(CAL_SAMPLES);
	endproperty
	a_cal_samples: assert property (p_cal_samples) else $error("calibration ended early");
	property p_cal_time;
		$fell(cal_busy_o) |-> cyc_cnt_q >= 16'(CAL_MOD_CLKS * MOD_DIV + CAL_OSC_CLKS * OSC_DIV);
	endproperty
	a_cal_time: assert property (p_cal_time) else $error("calibration too short");
	property p_short_busy;
		short_inputs_o |-> cal_busy_o;
	endproperty
	a_short_busy: assert property (p_short_busy) else $error("inputs shorted while idle");
endmodule

bind adcce_top adcce_checker #(
	.RESUME_CYC(RESUME_CYC),
	.MOD_DIV   (MOD_DIV),
	.OSC_DIV   (OSC_DIV)
) u_checker (
	.core_clk_i      (core_clk_i),
	.resetn_i        (resetn_i),
	.sclk_i          (sclk_i),
	.cs_n_i          (cs_n_i),
	.miso_oe_o       (miso_oe_o),
	.result_ready_n_o(result_ready_n_o),
	.conv_valid_i    (conv_valid_i),
	.short_inputs_o  (short_inputs_o),
	.cal_busy_o      (cal_busy_o),
	.hreadyout_o     (hreadyout_o),
	.hresp_o         (hresp_o)
);
`default_nettype wire

// [tb/adcce_host_model.sv]
// Host model: master side of the serial link
`timescale 1ns/10ps
`default_nettype none
module adcce_host_model (
	// Clock
	input  wire logic clk_i,
	// Serial link
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      mosi_o,
	input  wire logic miso_i
);
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end
	task automatic half();
		repeat (4) @(posedge clk_i);
	endtask
	// Clock idles low between frames
	task automatic sel();
		cs_n_o <= 1'b0;
		half();
		half();
	endtask
	// Released data line toggles so no stale level looks valid
	task automatic desel();
		half();
		cs_n_o <= 1'b1;
		mosi_o <= ~mosi_o;
		half();
		half();
	endtask
	// Whole bytes only, MSB first
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			mosi_o <= tx[i];
			half();
			sclk_o <= 1'b1;
			half();
			rx[i] = miso_i;
			sclk_o <= 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// [tb/adc_spi_command_engine_bench.sv]
// Bench: scenario tests of the serial command engine
`timescale 1ns/10ps
`default_nettype none
module adc_spi_command_engine_bench;
	import adcce_pkg::*;
	logic        clk, resetn, sclk, cs_n, mosi, miso;
	logic        conv_valid, short_in, cal_busy, ready_n;
	logic [23:0] conv_data;
	logic        hsel, hwrite, hready;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [7:0]  rx;
	logic [31:0] d;
	int          miscompares;
	int          samples_checked;

	adcce_top #(.RESUME_CYC(100), .MOD_DIV(1), .OSC_DIV(1)) uut (
		.core_clk_i(clk), .resetn_i(resetn), .ce_i(1'b1),
		.sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso), .miso_oe_o(),
		.result_ready_n_o(ready_n), .conv_valid_i(conv_valid), .conv_data_i(conv_data),
		.short_inputs_o(short_in), .cal_busy_o(cal_busy),
		.hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
		.hready_i(hready), .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o()
	);
	adcce_host_model host (.clk_i(clk), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ========
	// Shared tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hwrite <= wr;
		haddr <= a;
		htrans <= 2'h2;
		@(posedge clk);
		for (int n = 0; hready !== 1'b1 && n < 50; n++) @(posedge clk);
		if (hready !== 1'b1) begin
			miscompares++;
		end
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge clk);
		for (int n = 0; hready !== 1'b1 && n < 50; n++) @(posedge clk);
		if (hready !== 1'b1) begin
			miscompares++;
		end
		rd = hrdata;
	endtask
	task automatic rchk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
		ahb(1'b0, a, 32'h0, d);
		chk(d & m, e);
	endtask
	task automatic bx(input logic [7:0] tx, input logic [7:0] exp);
		host.xfer(tx, rx);
		chk({24'h0, rx}, {24'h0, exp});
	endtask
	task automatic res(input logic [23:0] e, input logic [7:0] last);
		bx(8'hff, e[23:16]);
		bx(8'hff, e[15:8]);
		bx(last, e[7:0]);
	endtask
	task automatic cmd(input logic [7:0] op);
		host.sel();
		host.xfer(op, rx);
		host.desel();
	endtask
	task automatic conv(input logic [23:0] v);
		conv_data <= v;
		conv_valid <= 1'b1;
		@(posedge clk);
		conv_valid <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	task automatic wait_busy(input logic lvl);
		for (int n = 0; cal_busy !== lvl && n < 400; n++) @(posedge clk);
		chk({31'h0, cal_busy}, {31'h0, lvl});
	endtask
	// ========
	// Scenarios
	task automatic test_reset();
		rchk(AHB_OFS_OFFSET, 32'hffffff, 32'h0);
		rchk(AHB_OFS_GAIN, 32'hffffff, 32'h400000);
		rchk(AHB_OFS_STATUS, 32'h2f, 32'h1);
		rchk(32'h40, 32'hffffffff, 32'h0);
		cmd(8'h0e);
		rchk(AHB_OFS_STATUS, 32'h20, 32'h20);
		repeat (150) @(posedge clk);
		rchk(AHB_OFS_STATUS, 32'h20, 32'h0);
		$display("test_reset done");
	endtask
	task automatic test_cont();
		conv(24'ha5c3e1);
		chk({31'h0, ready_n}, 32'h0);
		host.sel();
		res(24'ha5c3e1, 8'hff);
		host.desel();
		chk({31'h0, ready_n}, 32'h1);
		conv(24'h3c5a96);
		host.sel();
		bx(8'hff, 8'h3c);
		host.desel();
		conv(24'h123456);
		host.sel();
		bx(8'h41, 8'h12);
		bx(8'h00, 8'h34);
		bx(8'h5a, 8'h56);
		host.desel();
		$display("test_cont done");
	endtask
	task automatic test_regs();
		ahb(1'b1, AHB_OFS_CONTROL, 32'h26b, d);
		ahb(1'b1, 32'h44, 32'hffff, d);
		rchk(32'h44, 32'hffffffff, 32'h0);
		host.sel();
		host.xfer(8'h4f, rx);
		host.xfer(8'h01, rx);
		host.xfer(8'h81, rx);
		host.xfer(8'h82, rx);
		host.desel();
		host.sel();
		host.xfer(8'h2f, rx);
		host.xfer(8'h03, rx);
		bx(8'hff, 8'h81);
		bx(8'h16, 8'h82);
		bx(8'hff, 8'h5a);
		bx(8'hff, 8'h6b);
		host.desel();
		rchk(AHB_OFS_STATUS, 32'h0d, 32'h1);
		$display("test_regs done");
	endtask
	task automatic test_modes();
		cmd(8'h17);
		rchk(AHB_OFS_STATUS, 32'h05, 32'h5);
		conv(24'h0f1e2d);
		rchk(AHB_OFS_STATUS, 32'h05, 32'h0);
		conv(24'h778899);
		host.sel();
		host.xfer(8'h13, rx);
		res(24'h778899, 8'h12);
		res(24'h778899, 8'hff);
		host.desel();
		conv(24'h000555);
		cmd(8'h15);
		rchk(AHB_OFS_STATUS, 32'h09, 32'h8);
		conv(24'h000777);
		rchk(AHB_OFS_STATUS, 32'h09, 32'h1);
		$display("test_modes done");
	endtask
	task automatic test_cal();
		logic [23:0] v [3] = '{24'h000123, 24'h3fff00, 24'h0000a0};
		logic        s;
		for (int k = 0; k < 3; k++) begin
			cmd(8'h60 + 8'(k));
			wait_busy(1'b1);
			conv(v[k]);
			s = short_in;
			for (int n = 0; cal_busy && n < 40; n++) begin
				conv(v[k]);
			end
			wait_busy(1'b0);
			chk({31'h0, s}, {31'h0, k == 2});
			rchk(k == 1 ? AHB_OFS_GAIN : AHB_OFS_OFFSET, 32'hffffff, {8'h0, v[k]});
		end
		$display("test_cal done");
	endtask
	task automatic test_rst2();
		resetn <= 1'b0;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		repeat (8) @(posedge clk);
		rchk(AHB_OFS_OFFSET, 32'hffffff, 32'h0);
		rchk(AHB_OFS_STATUS, 32'h3f, 32'h1);
		conv(24'h5e6f70);
		host.sel();
		res(24'h5e6f70, 8'hff);
		host.desel();
		$display("test_rst2 done");
	endtask
	task automatic print_verdict();
		$display("checked %0d mismatched %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// ========
	// Main sequence and watchdog
	initial begin
		{resetn, conv_valid, conv_data, hsel, haddr, htrans, hwrite, hwdata} = '0;
		hsize = 3'h2;
		miscompares = 0;
		samples_checked = 0;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		hsel <= 1'b1;
		repeat (8) @(posedge clk);
		test_reset();
		test_cont();
		test_regs();
		test_modes();
		test_cal();
		test_rst2();
		print_verdict();
	end
	initial begin
		repeat (60000) @(posedge clk);
		miscompares++;
		print_verdict();
	end
endmodule
`default_nettype wire
